// ==== core/drive_monitor_status_regs.sv ====
// Read-only monitor register bank of the drive, reached by register number.
// Assumes the framer decodes requests and presents one access per pulse.
// Functional notes
// RULE_01: Monitor registers are read-only, reads never alter state.
// RULE_02: Writes are refused with write-mode error code.
// RULE_03: Input terminals one to seven on bits 0-6.
// RULE_04: Unused bits always read as zero.
// RULE_05: Bit 0 running, bit 1 zero speed.
// RULE_06: Bit 2 reference agree, bit 3 desired agree.
// RULE_07: Bit 4 when output at or below threshold.
// RULE_08: Bit 5 when output at or above threshold.
// RULE_09: Bit 6 set once startup completes.
// RULE_10: Low-voltage flag set when detected.
// RULE_11: Bit 8 set while output is baseblocked.
// RULE_12: Reference source flag, zero means link.
// RULE_13: Bit B overtorque, bit C reference lost.
// RULE_14: Bit D set during automatic fault retry.
// RULE_15: Bit E any error, time-out included; code ORs only the fault flag and time-out.
// RULE_16: Bit F set on communication time-out.
// RULE_17: Output contacts on bits 0 and 1.
// RULE_18: DC bus voltage readable as register.
// RULE_19: Feedback level unsigned, ten counts per percent.
// RULE_20: Two loop levels signed, ten counts per percent.
// RULE_21: Link error detail bit layout fixed.
// RULE_22: Error reset accepted even while running.
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_status_regs
   import monitor_bank_pkg::*;
#(
   // Arbitrary neutral software identifiers
   parameter logic [15:0] CPU_SW_NUMBER   = 16'h0001,
   parameter logic [15:0] FLASH_SW_NUMBER = 16'h0001
)
(
   // Clock and reset
   input  wire logic                 sys_clk_in,
   input  wire logic                 rstn_in,
   // Terminal pins
   input  wire logic [6:0]           input_terminal_in,
   input  wire logic [1:0]           output_contact_in,
   // Drive core state
   input  wire drive_flags_type      drive_flags_in,
   input  wire drive_values_type     drive_values_in,
   input  wire link_events_type      link_events_in,
   input  wire logic                 error_reset_in,
   input  wire logic [15:0]          power_rating_in,
   input  wire logic [15:0]          control_method_in,
   // Register access port
   input  wire logic                 req_valid_in,
   input  wire logic                 req_write_in,
   input  wire logic [ADDR_W-1:0]    req_addr_in,
   output logic                      ans_valid_out,
   output logic [DATA_W-1:0]         ans_data_out,
   output logic [7:0]                ans_code_out
);

   // Outcome of one register access
   typedef enum logic [1:0]
   {
      ACCESS_READ     = 2'b00,
      ACCESS_REFUSED  = 2'b01,
      ACCESS_UNMAPPED = 2'b10
   } access_kind_type;

   logic [6:0]       term_meta_q;
   logic [6:0]       term_sync_q;
   logic [1:0]       cont_meta_q;
   logic [1:0]       cont_sync_q;
   logic [5:0]       link_err_q;
   logic [5:0]       link_event_vec;
   logic [15:0]      cond_word;
   logic [15:0]      seq_word;
   logic [15:0]      contact_word;
   logic [15:0]      link_word;
   logic [15:0]      read_word;
   logic             addr_hit;
   logic             any_error;
   access_kind_type  access_kind;

   function automatic logic is_mapped(input logic [15:0] addr);
      case (addr)
         REG_SEQ_INPUT, REG_DRIVE_COND, REG_OUT_CONTACT, REG_DC_BUS,
         REG_LOOP_FB, REG_LOOP_A, REG_LOOP_B, REG_CPU_SW, REG_FLASH_SW,
         REG_LINK_ERR, REG_POWER_RATE, REG_CTRL_METHOD:
            is_mapped = 1'b1;
         default:
            is_mapped = 1'b0;
      endcase
   endfunction

   // Pins come from outside the clock domain; two flops per bit
   for (genvar t = 0; t < INPUT_COUNT; t++)
   begin : g_term_sync
      always_ff @(posedge sys_clk_in or negedge rstn_in)
      begin
         if (!rstn_in)
         begin
            term_meta_q[t] <= 1'h0;
            term_sync_q[t] <= 1'h0;
         end
         else
         begin
            term_meta_q[t] <= input_terminal_in[t];
            term_sync_q[t] <= term_meta_q[t];
         end
      end
   end

   for (genvar k = 0; k < CONTACT_COUNT; k++)
   begin : g_cont_sync
      always_ff @(posedge sys_clk_in or negedge rstn_in)
      begin
         if (!rstn_in)
         begin
            cont_meta_q[k] <= 1'h0;
            cont_sync_q[k] <= 1'h0;
         end
         else
         begin
            cont_meta_q[k] <= output_contact_in[k];
            cont_sync_q[k] <= cont_meta_q[k];
         end
      end
   end

   // Event vector: crc in bit 0 up to time-out in bit 5
   assign link_event_vec = link_events_in;

   // Sticky link errors; a new event wins over the error reset so no error is lost
   for (genvar e = 0; e < $bits(link_events_type); e++)
   begin : g_sticky
      always_ff @(posedge sys_clk_in or negedge rstn_in)
      begin
         if (!rstn_in)
         begin
            link_err_q[e] <= 1'h0;
         end
         else if (link_event_vec[e])
         begin
            link_err_q[e] <= 1'h1;
         end
         else if (error_reset_in) // RULE_22
         begin
            link_err_q[e] <= 1'h0;
         end
      end
   end

   assign any_error = drive_flags_in.fault | link_err_q[5]; // RULE_15

   always_comb
   begin
      cond_word                  = RESET_WORD;
      cond_word[COND_RUN]        = drive_flags_in.running; // RULE_05
      cond_word[COND_ZERO_SPD]   = drive_flags_in.zero_speed; // RULE_05
      cond_word[COND_FREQ_AGREE] = drive_flags_in.freq_agree; // RULE_06
      cond_word[COND_DES_AGREE]  = drive_flags_in.desired_agree; // RULE_06
      cond_word[COND_DET_LOW]    = drive_values_in.out_freq <= drive_values_in.freq_threshold; // RULE_07
      cond_word[COND_DET_HIGH]   = drive_values_in.out_freq >= drive_values_in.freq_threshold; // RULE_08
      cond_word[COND_READY]      = drive_flags_in.startup_done; // RULE_09
      cond_word[COND_LOW_VOLT]   = drive_flags_in.low_voltage; // RULE_10
      cond_word[COND_BASEBLOCK]  = drive_flags_in.baseblock; // RULE_11
      cond_word[COND_REF_REMOTE] = drive_flags_in.ref_not_link; // RULE_12
      cond_word[COND_OVERTORQUE] = drive_flags_in.overtorque; // RULE_13
      cond_word[COND_REF_LOST]   = drive_flags_in.ref_lost; // RULE_13
      cond_word[COND_RETRY]      = drive_flags_in.retrying; // RULE_14
      cond_word[COND_ERROR]      = any_error; // RULE_15
      cond_word[COND_TIMEOUT]    = link_err_q[5]; // RULE_16
   end

   // Bits above the seventh terminal stay zero
   always_comb
   begin
      seq_word                  = RESET_WORD; // RULE_04
      seq_word[INPUT_COUNT-1:0] = term_sync_q; // RULE_03
   end

   always_comb
   begin
      contact_word                    = RESET_WORD; // RULE_04
      contact_word[CONTACT_COUNT-1:0] = cont_sync_q; // RULE_17
   end

   // Bit 2 and the upper byte are never set
   always_comb
   begin
      link_word               = RESET_WORD; // RULE_04
      link_word[LERR_CRC]     = link_err_q[0]; // RULE_21
      link_word[LERR_LENGTH]  = link_err_q[1];
      link_word[LERR_PARITY]  = link_err_q[2];
      link_word[LERR_OVERRUN] = link_err_q[3];
      link_word[LERR_FRAMING] = link_err_q[4];
      link_word[LERR_TIMEOUT] = link_err_q[5];
   end

   // Pure read mux; nothing here touches stored state
   always_comb
   begin
      read_word = RESET_WORD;
      case (req_addr_in)
         REG_SEQ_INPUT:   read_word = seq_word;
         REG_DRIVE_COND:  read_word = cond_word;
         REG_OUT_CONTACT: read_word = contact_word;
         REG_DC_BUS:      read_word = drive_values_in.dc_bus; // RULE_18
         REG_LOOP_FB:     read_word = drive_values_in.loop_feedback; // RULE_19
         REG_LOOP_A:      read_word = drive_values_in.loop_level_a; // RULE_20
         REG_LOOP_B:      read_word = drive_values_in.loop_level_b; // RULE_20
         REG_CPU_SW:      read_word = CPU_SW_NUMBER;
         REG_FLASH_SW:    read_word = FLASH_SW_NUMBER;
         REG_LINK_ERR:    read_word = link_word;
         REG_POWER_RATE:  read_word = power_rating_in;
         REG_CTRL_METHOD: read_word = control_method_in;
         default:         read_word = RESET_WORD; // RULE_04
      endcase
   end

   assign addr_hit = is_mapped(req_addr_in);

   // Unmapped wins over write, so a write to a hole reports a bad address
   always_comb
   begin
      if (!addr_hit)
      begin
         access_kind = ACCESS_UNMAPPED;
      end
      else if (req_write_in)
      begin
         access_kind = ACCESS_REFUSED; // RULE_02
      end
      else
      begin
         access_kind = ACCESS_READ;
      end
   end

   // Answer strobe follows each request by one cycle
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ans_valid_out <= 1'h0;
      end
      else
      begin
         ans_valid_out <= req_valid_in;
      end
   end

   // Data holds until the next answer; refused accesses return zero
   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ans_data_out <= RESET_WORD;
      end
      else if (req_valid_in)
      begin
         case (access_kind)
            ACCESS_READ:
            begin
               ans_data_out <= read_word; // RULE_01
            end
            default:
            begin
               ans_data_out <= RESET_WORD; // RULE_01
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ans_code_out <= ANS_OK;
      end
      else if (req_valid_in)
      begin
         case (access_kind)
            ACCESS_READ:     ans_code_out <= ANS_OK;
            ACCESS_REFUSED:  ans_code_out <= ANS_WRITE_MODE; // RULE_02
            ACCESS_UNMAPPED: ans_code_out <= ANS_BAD_ADDR;
            default:         ans_code_out <= ANS_BAD_ADDR;
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== core/monitor_bank_pkg.sv ====
// Package for the drive monitor register bank.
// Holds register numbers, bit positions and the status carrier type.
package monitor_bank_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // Register numbers
   localparam logic [15:0] REG_SEQ_INPUT   = 16'h002B;
   localparam logic [15:0] REG_DRIVE_COND  = 16'h002C;
   localparam logic [15:0] REG_OUT_CONTACT = 16'h002D;
   localparam logic [15:0] REG_DC_BUS      = 16'h0031;
   localparam logic [15:0] REG_LOOP_FB     = 16'h0038;
   localparam logic [15:0] REG_LOOP_A      = 16'h0039;
   localparam logic [15:0] REG_LOOP_B      = 16'h003A;
   localparam logic [15:0] REG_CPU_SW      = 16'h003B;
   localparam logic [15:0] REG_FLASH_SW    = 16'h003C;
   localparam logic [15:0] REG_LINK_ERR    = 16'h003D;
   localparam logic [15:0] REG_POWER_RATE  = 16'h003E;
   localparam logic [15:0] REG_CTRL_METHOD = 16'h003F;

   // Drive condition word bit positions
   localparam int unsigned COND_RUN        = 0;
   localparam int unsigned COND_ZERO_SPD   = 1;
   localparam int unsigned COND_FREQ_AGREE = 2;
   localparam int unsigned COND_DES_AGREE  = 3;
   localparam int unsigned COND_DET_LOW    = 4;
   localparam int unsigned COND_DET_HIGH   = 5;
   localparam int unsigned COND_READY      = 6;
   localparam int unsigned COND_LOW_VOLT   = 7;
   localparam int unsigned COND_BASEBLOCK  = 8;
   localparam int unsigned COND_REF_REMOTE = 9;
   localparam int unsigned COND_OVERTORQUE = 11;
   localparam int unsigned COND_REF_LOST   = 12;
   localparam int unsigned COND_RETRY      = 13;
   localparam int unsigned COND_ERROR      = 14;
   localparam int unsigned COND_TIMEOUT    = 15;

   // Link error detail bit positions
   localparam int unsigned LERR_CRC     = 0;
   localparam int unsigned LERR_LENGTH  = 1;
   localparam int unsigned LERR_PARITY  = 3;
   localparam int unsigned LERR_OVERRUN = 4;
   localparam int unsigned LERR_FRAMING = 5;
   localparam int unsigned LERR_TIMEOUT = 6;

   localparam int unsigned INPUT_COUNT   = 7;
   localparam int unsigned CONTACT_COUNT = 2;

   // Answer codes
   localparam logic [7:0] ANS_OK          = 8'h00;
   localparam logic [7:0] ANS_BAD_ADDR    = 8'h02;
   localparam logic [7:0] ANS_WRITE_MODE  = 8'h22;

   localparam logic [15:0] RESET_WORD = 16'h0000;

   // Drive state flags delivered by the drive core
   typedef struct packed {
      logic running;
      logic zero_speed;
      logic freq_agree;
      logic desired_agree;
      logic startup_done;
      logic low_voltage;
      logic baseblock;
      logic ref_not_link;
      logic overtorque;
      logic ref_lost;
      logic retrying;
      logic fault;
   } drive_flags_type;

   // Link error events, one-cycle pulses from the framer
   typedef struct packed {
      logic timeout;
      logic framing;
      logic overrun;
      logic parity;
      logic length;
      logic crc;
   } link_events_type;

   // Analogue measurements
   typedef struct packed {
      logic [15:0] out_freq;
      logic [15:0] freq_threshold;
      logic [15:0] dc_bus;
      logic [15:0] loop_feedback;
      logic [15:0] loop_level_a;
      logic [15:0] loop_level_b;
   } drive_values_type;

endpackage

// ==== testbench/drive_monitor_status_regs_chk.sv ====
// Port checker for the monitor register bank.
// Assumes one clock and the active-low reset of the bank.
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_status_regs_chk
   import monitor_bank_pkg::*;
(
   // Clock, reset, drive state
   input wire logic             sys_clk_in,
   input wire logic             rstn_in,
   input wire drive_flags_type  drive_flags_in,
   input wire drive_values_type drive_values_in,
   input wire link_events_type  link_events_in,
   input wire logic             error_reset_in,
   // Access port
   input wire logic             req_valid_in,
   input wire logic             req_write_in,
   input wire logic [15:0]      req_addr_in,
   input wire logic             ans_valid_out,
   input wire logic [15:0]      ans_data_out,
   input wire logic [7:0]       ans_code_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   logic mapped;
   assign mapped = req_addr_in inside {REG_SEQ_INPUT, REG_DRIVE_COND, REG_OUT_CONTACT, REG_DC_BUS, REG_LOOP_FB,
      REG_LOOP_A, REG_LOOP_B, REG_CPU_SW, REG_FLASH_SW, REG_LINK_ERR, REG_POWER_RATE, REG_CTRL_METHOD};
   sequence rd_of(logic [15:0] a);
      req_valid_in && !req_write_in && req_addr_in == a;
   endsequence
   sequence timeout_then_rd;
      link_events_in.timeout && !error_reset_in ##1 rd_of(REG_DRIVE_COND);
   endsequence
   sequence collide_then_rd;
      link_events_in.timeout && error_reset_in ##1 rd_of(REG_DRIVE_COND);
   endsequence
   AST_ANS_PULSE: assert property (!req_valid_in |=> !ans_valid_out) else $error("answer without request");
   AST_SET_WINS: assert property (collide_then_rd |=> ans_data_out[15] && ans_data_out[14])
      else $error("time-out lost to error reset");
   AST_ONE_ANSWER: assert property (req_valid_in |=> ans_valid_out) else $error("answer missing");
   AST_WRITE_REFUSED: assert property (req_valid_in && req_write_in && mapped |=>
      ans_code_out == ANS_WRITE_MODE && ans_data_out == 16'h0000) else $error("write not refused");
   AST_INPUT_UNUSED: assert property (rd_of(REG_SEQ_INPUT) |=> ans_data_out[15:7] == 9'h000)
      else $error("unused input bits set");
   AST_RUN_BIT: assert property (rd_of(REG_DRIVE_COND) |=>
      ans_data_out[0] == $past(drive_flags_in.running) && !ans_data_out[10]) else $error("run bit wrong");
   AST_DET_LOW: assert property (rd_of(REG_DRIVE_COND) |=> ans_data_out[4] ==
      ($past(drive_values_in.out_freq) <= $past(drive_values_in.freq_threshold))) else $error("low detect wrong");
   AST_DET_HIGH: assert property (rd_of(REG_DRIVE_COND) |=> ans_data_out[5] ==
      ($past(drive_values_in.out_freq) >= $past(drive_values_in.freq_threshold))) else $error("high detect wrong");
   AST_CONTACT_UNUSED: assert property (rd_of(REG_OUT_CONTACT) |=> ans_data_out[15:2] == 14'h0000)
      else $error("contact word unused bits set");
   AST_LOOP_B: assert property (rd_of(REG_LOOP_B) |=> ans_data_out == $past(drive_values_in.loop_level_b))
      else $error("loop level b wrong");
   AST_TIMEOUT_STICKY: assert property (timeout_then_rd |=> ans_data_out[15] && ans_data_out[14])
      else $error("time-out not reported");
endmodule
bind drive_monitor_status_regs drive_monitor_status_regs_chk u_chk (.sys_clk_in, .rstn_in, .drive_flags_in,
   .drive_values_in, .link_events_in, .error_reset_in, .req_valid_in, .req_write_in, .req_addr_in, .ans_valid_out,
   .ans_data_out, .ans_code_out);
`default_nettype wire

// ==== testbench/drive_monitor_status_regs_test.sv ====
// Self-checking bench of the monitor register bank.
// Assumes the master model and the checker bound to the bank.
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_status_regs_test
   import monitor_bank_pkg::*;
;
   logic             sys_clk_in, rstn_in, error_reset_in, req_valid_in, req_write_in, ans_valid_out;
   logic [6:0]       input_terminal_in;
   logic [1:0]       output_contact_in;
   drive_flags_type  drive_flags_in;
   drive_values_type drive_values_in;
   link_events_type  link_events_in;
   logic [15:0]      power_rating_in, control_method_in, req_addr_in, ans_data_out, d;
   logic [7:0]       ans_code_out, c;
   int               fails, check_count, lerr, seed = 32'hE688;
   int               pos[6] = '{0, 1, 3, 4, 5, 6};
   logic [15:0]      unm[6] = '{16'h002E, 16'h0030, 16'h0032, 16'h0037, 16'h0040, 16'hFFFF};
   logic [15:0]      regs[12] = '{REG_SEQ_INPUT, REG_DRIVE_COND, REG_OUT_CONTACT, REG_DC_BUS, REG_LOOP_FB,
      REG_LOOP_A, REG_LOOP_B, REG_CPU_SW, REG_FLASH_SW, REG_LINK_ERR, REG_POWER_RATE, REG_CTRL_METHOD};
   drive_monitor_status_regs #(.CPU_SW_NUMBER(16'h1234), .FLASH_SW_NUMBER(16'h5678)) u_dut (.sys_clk_in,
      .rstn_in, .input_terminal_in, .output_contact_in, .drive_flags_in, .drive_values_in, .link_events_in,
      .error_reset_in, .power_rating_in, .control_method_in, .req_valid_in, .req_write_in, .req_addr_in,
      .ans_valid_out, .ans_data_out, .ans_code_out);
   monitor_master u_master (.clk_in(sys_clk_in), .req_valid_out(req_valid_in), .req_write_out(req_write_in),
      .req_addr_out(req_addr_in), .ans_valid_in(ans_valid_out), .ans_data_in(ans_data_out), .ans_code_in(ans_code_out));
   function automatic logic [15:0] exp_of(input logic [15:0] a);
      drive_flags_type  f;
      drive_values_type v;
      f = drive_flags_in;
      v = drive_values_in;
      case (a)
         REG_SEQ_INPUT:   return {9'h000, input_terminal_in};
         REG_DRIVE_COND:  return {lerr[6], f.fault | lerr[6], f.retrying, f.ref_lost, f.overtorque, 1'b0,
            f.ref_not_link, f.baseblock, f.low_voltage, f.startup_done, v.out_freq >= v.freq_threshold,
            v.out_freq <= v.freq_threshold, f.desired_agree, f.freq_agree, f.zero_speed, f.running};
         REG_OUT_CONTACT: return {14'h0000, output_contact_in};
         REG_DC_BUS:      return v.dc_bus;
         REG_LOOP_FB:     return v.loop_feedback;
         REG_LOOP_A:      return v.loop_level_a;
         REG_LOOP_B:      return v.loop_level_b;
         REG_CPU_SW:      return 16'h1234;
         REG_FLASH_SW:    return 16'h5678;
         REG_LINK_ERR:    return 16'(lerr);
         REG_POWER_RATE:  return power_rating_in;
         REG_CTRL_METHOD: return control_method_in;
         default:         return 16'h0000;
      endcase
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic wr);
      u_master.access(wr, a, d, c);
      check($sformatf("data %h", a), d, wr ? 16'h0000 : exp_of(a));
      check($sformatf("code %h", a), c, wr ? ANS_WRITE_MODE : (a inside {regs}) ? ANS_OK : ANS_BAD_ADDR);
   endtask
   task automatic step;
      @(posedge sys_clk_in);
      #10;
   endtask
   task automatic give_verdict;
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   initial
   begin
      #6000000;
      fails++;
      give_verdict();
   end
   initial
   begin
      {rstn_in, error_reset_in, input_terminal_in, output_contact_in, power_rating_in, control_method_in} = '0;
      {drive_flags_in, drive_values_in, link_events_in} = '0;
      lerr = 0;
      repeat (16) @(posedge sys_clk_in);
      #10;
      rstn_in = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         step();
         drive_flags_in = 12'($random(seed));
         drive_values_in = {$random(seed), $random(seed), $random(seed)};
         {input_terminal_in, output_contact_in, power_rating_in, control_method_in} = 41'({$random(seed), $random(seed)});
         if (i % 3 == 0)
            drive_values_in.freq_threshold = drive_values_in.out_freq;
         if (i % 4 == 3)
         begin
            // Clear while running must still work
            drive_flags_in.running = 1'b1;
            step();
            error_reset_in = 1'b1;
            step();
            error_reset_in = 1'b0;
            lerr = 0;
         end
         link_events_in = 6'(1 << (i % 6));
         lerr |= 1 << pos[i % 6];
         fork
            rd(REG_DRIVE_COND, 1'b0);
            begin
               step();
               link_events_in = '0;
            end
         join
         repeat (2) @(posedge sys_clk_in);
         foreach (regs[j]) rd(regs[j], 1'b0);
         rd(regs[i], 1'b1);
         rd(regs[i], 1'b0);
         rd(unm[i % 6], 1'b0);
      end
      // Event and error reset in one cycle: the event survives
      link_events_in.timeout = 1'b1;
      error_reset_in = 1'b1;
      lerr = 1 << 6;
      fork
         rd(REG_DRIVE_COND, 1'b0);
         begin
            step();
            {link_events_in, error_reset_in} = '0;
         end
      join
      rd(REG_LINK_ERR, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire

// ==== testbench/monitor_master.sv ====
// Master model that issues one register access at a time.
// Assumes the bank answers one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none
module monitor_master
   import monitor_bank_pkg::*;
(
   // Clock
   input  wire logic        clk_in,
   // Request side
   output logic             req_valid_out,
   output logic             req_write_out,
   output logic [15:0]      req_addr_out,
   // Answer side
   input  wire logic        ans_valid_in,
   input  wire logic [15:0] ans_data_in,
   input  wire logic [7:0]  ans_code_in
);
   initial
   begin
      req_valid_out = 1'b0;
      req_write_out = 1'b0;
      req_addr_out = 16'h0000;
   end
   task automatic access(input logic wr, input logic [15:0] a, output logic [15:0] d, output logic [7:0] c);
      @(posedge clk_in);
      #10;
      req_valid_out = 1'b1;
      req_write_out = wr;
      req_addr_out = a;
      @(posedge clk_in);
      #10;
      req_valid_out = 1'b0;
      // Released fields show garbage, not the old value
      req_write_out = ~wr;
      req_addr_out = ~a;
      d = ans_data_in;
      // Missing answer turns into a code no bank uses
      c = ans_valid_in ? ans_code_in : 8'hFF;
   endtask
endmodule
`default_nettype wire
